// *** bmp_pkg.sv ***
// Summary of operation
// - Data path is eight bits, two-way, tri-state; master strobes set direction.
// - Permanent master floats data drivers while a temporary master requests the bus.
// - Permanent master floats address drivers while a temporary master requests the bus.
// - Master drives sixteen address lines decoded for memory or I/O space.
// - With expansion, D0 to D3 carry A16 to A19 multiplexed with data.
// - Meaningful address width depends on processor; refresh uses only lower lines.
// - Master drives write strobe low while valid write data is on the bus.
// - A control card may raise memory expansion select to overlay primary memory.
// - Master releases lines at end of cycle and asserts bus acknowledge on the same clock edge.
// - While wait request is low in the strobe phase, master holds the cycle and address valid; setup and hold phases ignore it.
package bmp_pkg;
    localparam int DW = 8;
    localparam int AW = 16;
    localparam int XW = 4;
    localparam int FIFO_DEPTH = 4;
    // Phase lengths in clock cycles at 200 MHz, rounded up to whole cycles.
    // Integer arithmetic keeps the counts usable by tools without real support.
    localparam int CLK_NS = 5;
    localparam int ADDR_SETUP_NS = 20;
    localparam int STROBE_NS = 40;
    localparam int HOLD_NS = 10;
    localparam logic [3:0] SETUP_CYC  = 4'((ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CNT_ONE    = 4'h1;
    localparam logic [3:0] CNT_ZERO   = 4'h0;

    typedef enum logic [1:0] {
        BMP_MEM_RD,
        BMP_MEM_WR,
        BMP_IO_RD,
        BMP_IO_WR
    } bmp_op_t;

    typedef struct packed {
        bmp_op_t           op;
        logic              expand;
        logic              ext_en;
        logic [XW-1:0]     ext_addr;
        logic [AW-1:0]     addr;
        logic [DW-1:0]     wdata;
    } bmp_req_t;

    typedef struct packed {
        logic              nwr;
        logic              nrd;
        logic              niorq;
        logic              nmemrq;
        logic              ioexp;
        logic              memex;
    } bmp_ctl_t;
endpackage

// *** bmp_fifo.sv ***
`timescale 1ns/10ps
module bmp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r;
    logic [PW-1:0]    rp_r;
    logic [PW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// *** bmp_master.sv ***
`timescale 1ns/10ps
module bmp_master (
    // Clock and reset.
    input  wire logic                    SYS_CLK,
    input  wire logic                    SYS_RST,
    // Request side.
    input  wire logic                    REQ_VALID,
    output logic                         REQ_READY,
    input  wire bmp_pkg::bmp_req_t       REQ,
    // Read data side.
    output logic                         RSP_VALID,
    input  wire logic                    RSP_READY,
    output logic [bmp_pkg::DW-1:0]       RSP_DATA,
    // Backplane data and address.
    input  wire logic [bmp_pkg::DW-1:0]  BUS_D_I,
    output logic      [bmp_pkg::DW-1:0]  BUS_D_O,
    output logic                         BUS_D_OE,
    output logic      [bmp_pkg::AW-1:0]  BUS_A_O,
    output logic                         BUS_A_OE,
    // Backplane control.
    output bmp_pkg::bmp_ctl_t            BUS_CTL_O,
    output logic                         BUS_CTL_OE,
    input  wire logic                    BUS_WAIT_N,
    input  wire logic                    BUS_REQ_N,
    output logic                         BUS_ACK_N,
    input  wire logic                    BUS_PWRDN_N,
    output logic                         PWR_FAIL
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_XADDR, ST_SETUP, ST_STROBE, ST_HOLD, ST_PARK
    } bmp_st_t;

    bmp_st_t              st_r;
    bmp_pkg::bmp_req_t    cur_r;
    logic [3:0]           cnt_r;
    logic [1:0]           wait_s;
    logic [1:0]           breq_s;
    logic [1:0]           pd_s;
    logic [bmp_pkg::DW-1:0] rdata_r;
    logic                 rd_push;
    logic                 fifo_in_ready;
    logic                 is_rd;
    logic                 is_io;

    // Pin synchronisers.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            wait_s <= 2'h3;
            breq_s <= 2'h3;
            pd_s   <= 2'h3;
        end else begin
            wait_s <= {wait_s[0], BUS_WAIT_N};
            breq_s <= {breq_s[0], BUS_REQ_N};
            pd_s   <= {pd_s[0], BUS_PWRDN_N};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PWR_FAIL <= 1'b0;
        end else begin
            PWR_FAIL <= ~pd_s[1];
        end
    end

    assign is_rd = (cur_r.op == bmp_pkg::BMP_MEM_RD) || (cur_r.op == bmp_pkg::BMP_IO_RD);
    assign is_io = (cur_r.op == bmp_pkg::BMP_IO_RD) || (cur_r.op == bmp_pkg::BMP_IO_WR);

    // A new request is only taken while the bus is ours and the read FIFO has room,
    // so a stalled reader holds off further bus cycles.
    assign REQ_READY = (st_r == ST_IDLE) && breq_s[1] && fifo_in_ready;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            st_r  <= ST_IDLE;
            cur_r <= '0;
            cnt_r <= bmp_bmp_zero();
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (!breq_s[1]) begin
                        st_r <= ST_PARK;
                    end else if (REQ_VALID && REQ_READY) begin
                        cur_r <= REQ;
                        cnt_r <= bmp_pkg::SETUP_CYC;
                        st_r  <= REQ.ext_en ? ST_XADDR : ST_SETUP;
                    end
                end
                ST_XADDR: begin
                    if (cnt_r == bmp_pkg::CNT_ONE) begin
                        cnt_r <= bmp_pkg::SETUP_CYC;
                        st_r  <= ST_SETUP;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                ST_SETUP: begin
                    if (cnt_r == bmp_pkg::CNT_ONE) begin
                        cnt_r <= bmp_pkg::STROBE_CYC;
                        st_r  <= ST_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                ST_STROBE: begin
                    if (!wait_s[1]) begin
                        cnt_r <= cnt_r;
                    end else if (cnt_r == bmp_pkg::CNT_ONE) begin
                        cnt_r <= bmp_pkg::HOLD_CYC;
                        st_r  <= ST_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                ST_HOLD: begin
                    if (cnt_r == bmp_pkg::CNT_ONE) begin
                        st_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                ST_PARK: begin
                    if (breq_s[1]) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    function automatic logic [3:0] bmp_bmp_zero();
        return bmp_pkg::CNT_ZERO;
    endfunction

    // Read data is captured at the last strobe cycle, while the strobe is still low.
    assign rd_push = (st_r == ST_STROBE) && wait_s[1] && (cnt_r == bmp_pkg::CNT_ONE) && is_rd;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rdata_r <= '0;
        end else if (rd_push) begin
            rdata_r <= BUS_D_I;
        end
    end

    // Pin drive, registered so the backplane sees clean edges.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            BUS_A_O    <= '0;
            BUS_A_OE   <= 1'b0;
            BUS_CTL_OE <= 1'b0;
            BUS_ACK_N  <= 1'b1;
            BUS_D_O    <= '0;
            BUS_D_OE   <= 1'b0;
            BUS_CTL_O  <= '1;
        end else begin
            BUS_ACK_N  <= ~(st_r == ST_PARK);
            BUS_A_OE   <= (st_r != ST_PARK);
            BUS_CTL_OE <= (st_r != ST_PARK);
            BUS_A_O    <= cur_r.addr;
            BUS_CTL_O.ioexp <= cur_r.expand && is_io;
            BUS_CTL_O.memex <= cur_r.expand && !is_io;
            BUS_CTL_O.niorq  <= ~(is_io && (st_r == ST_SETUP || st_r == ST_STROBE
                                            || st_r == ST_HOLD));
            BUS_CTL_O.nmemrq <= ~(!is_io && (st_r == ST_SETUP || st_r == ST_STROBE
                                             || st_r == ST_HOLD));
            BUS_CTL_O.nrd <= ~(is_rd && st_r == ST_STROBE);
            BUS_CTL_O.nwr <= ~(!is_rd && st_r == ST_STROBE);
            if (st_r == ST_XADDR) begin
                BUS_D_O  <= {{(bmp_pkg::DW-bmp_pkg::XW){1'b0}}, cur_r.ext_addr};
                BUS_D_OE <= 1'b1;
            end else if (!is_rd && (st_r == ST_SETUP || st_r == ST_STROBE)) begin
                BUS_D_O  <= cur_r.wdata;
                BUS_D_OE <= 1'b1;
            end else begin
                BUS_D_O  <= BUS_D_O;
                BUS_D_OE <= 1'b0;
            end
        end
    end

    logic rd_push_d;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rd_push_d <= 1'b0;
        end else begin
            rd_push_d <= rd_push;
        end
    end

    bmp_fifo #(.WIDTH(bmp_pkg::DW), .DEPTH(bmp_pkg::FIFO_DEPTH)) u_rfifo (
        .clk       (SYS_CLK),
        .rst       (SYS_RST),
        .in_valid  (rd_push_d),
        .in_ready  (fifo_in_ready),
        .in_data   (rdata_r),
        .out_valid (RSP_VALID),
        .out_ready (RSP_READY),
        .out_data  (RSP_DATA)
    );
endmodule

// *** bmp_master_chk.sv ***
`timescale 1ns/10ps
module bmp_master_chk (
    // Clock and reset.
    input wire logic              SYS_CLK,
    input wire logic              SYS_RST,
    // Watched bus pins.
    input wire logic              BUS_D_OE,
    input wire logic [15:0]       BUS_A_O,
    input wire logic              BUS_A_OE,
    input wire bmp_pkg::bmp_ctl_t BUS_CTL_O,
    input wire logic              BUS_CTL_OE,
    input wire logic              BUS_ACK_N,
    input wire logic              BUS_PWRDN_N,
    input wire logic              PWR_FAIL
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    a_rd_float: assert property (BUS_CTL_OE && !BUS_CTL_O.nrd |-> !BUS_D_OE)
        else $error("data driven during read");
    a_wr_drive: assert property (BUS_CTL_OE && !BUS_CTL_O.nwr |-> BUS_D_OE)
        else $error("write strobe without data");
    a_grant_float: assert property (!BUS_ACK_N |-> !BUS_D_OE && !BUS_A_OE && !BUS_CTL_OE)
        else $error("lines driven while granted");
    a_one_space: assert property (BUS_CTL_OE |-> BUS_CTL_O.niorq || BUS_CTL_O.nmemrq)
        else $error("both requests low");
    a_strobe_qual: assert property (BUS_CTL_OE && !(BUS_CTL_O.nrd && BUS_CTL_O.nwr)
        |-> !(BUS_CTL_O.niorq && BUS_CTL_O.nmemrq))
        else $error("strobe without request");
    a_addr_hold: assert property (!BUS_CTL_O.nrd && !$past(BUS_CTL_O.nrd) |-> $stable(BUS_A_O))
        else $error("address moved in read");
    a_strobe_len: assert property ($fell(BUS_CTL_O.nrd) |-> !BUS_CTL_O.nrd [*8])
        else $error("read strobe too short");
    a_pwr_flag: assert property (!BUS_PWRDN_N [*5] |-> PWR_FAIL)
        else $error("power fail not flagged");
endmodule

// *** bmp_slave_model.sv ***
`timescale 1ns/10ps
module bmp_slave_model (
    // Bus as seen by the card.
    input  wire logic              clk,
    input  wire logic [15:0]       a,
    input  wire logic [7:0]        d,
    input  wire bmp_pkg::bmp_ctl_t ctl,
    input  wire logic              ctl_oe,
    // Read data and latched expansion bits.
    output logic [7:0]             q,
    output logic                   q_oe,
    output logic [3:0]             ext_q
);
    // One bank per space and select, so a crossed decode reads the wrong bank.
    // Static storage, so the refresh strobe has nothing to do here.
    logic [7:0] mem [0:63];
    logic [7:0] d_prev;
    logic       sel;
    logic       sel_prev;
    logic [5:0] idx;

    // The master never raises an interrupt acknowledge, so an I/O request is plain I/O.
    assign sel = ctl_oe && (ctl.niorq != ctl.nmemrq);
    assign idx = {!ctl.niorq, ctl.niorq ? ctl.memex : ctl.ioexp, a[3:0]};
    assign q_oe = sel && !ctl.nrd;
    assign q = mem[idx];
    always @(posedge clk) begin
        if (sel && !ctl.nwr) begin
            mem[idx] <= d;
        end
        if (sel && !sel_prev) begin
            ext_q <= d_prev[3:0];
        end
        d_prev <= d;
        sel_prev <= sel;
    end
endmodule

// *** bmp_master_tb_top.sv ***
`timescale 1ns/10ps
module bmp_master_tb_top;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              req_v = 1'b0;
    logic              rsp_r = 1'b0;
    logic              wait_n = 1'b1;
    logic              brq_n = 1'b1;
    logic              pd_n = 1'b1;
    logic [7:0]        last_d = 8'h00;
    bmp_pkg::bmp_req_t req = '0;
    bmp_pkg::bmp_ctl_t ctl;
    logic [7:0]        d_i, d_o, s_q, rsp_d;
    logic [15:0]       a_o;
    logic [3:0]        ext_q;
    logic              req_r, rsp_v, d_oe, a_oe, ctl_oe, ack_n, pfail, s_oe;
    int                fails = 0;
    int                total_checks = 0;

    always #2.5 clk = ~clk;
    // Nobody driving: the data lines wander so a stale value cannot pass.
    assign d_i = d_oe ? d_o : (s_oe ? s_q : ~last_d);
    always @(posedge clk) last_d <= d_i;

    bmp_master DUT (.SYS_CLK(clk), .SYS_RST(rst), .REQ_VALID(req_v), .REQ_READY(req_r),
        .REQ(req), .RSP_VALID(rsp_v), .RSP_READY(rsp_r), .RSP_DATA(rsp_d), .BUS_D_I(d_i),
        .BUS_D_O(d_o), .BUS_D_OE(d_oe), .BUS_A_O(a_o), .BUS_A_OE(a_oe), .BUS_CTL_O(ctl),
        .BUS_CTL_OE(ctl_oe), .BUS_WAIT_N(wait_n), .BUS_REQ_N(brq_n), .BUS_ACK_N(ack_n),
        .BUS_PWRDN_N(pd_n), .PWR_FAIL(pfail));
    bmp_slave_model u_slv (.clk(clk), .a(a_o), .d(d_i), .ctl(ctl), .ctl_oe(ctl_oe),
        .q(s_q), .q_oe(s_oe), .ext_q(ext_q));

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic do_op(input logic [1:0] o, input logic x, input logic e,
                         input logic [3:0] ea, input logic [7:0] wd);
        int n = 0;
        step;
        req = '{op: bmp_pkg::bmp_op_t'(o), expand: x, ext_en: e, ext_addr: ea,
                addr: 16'h0005, wdata: wd};
        req_v = 1'b1;
        while (req_r !== 1'b1 && n < 200) begin
            step;
            n++;
        end
        chk("req_ready", 8'h01, {7'h00, req_r});
        step;
        req_v = 1'b0;
    endtask

    task automatic get_rsp(input logic [7:0] e);
        int n = 0;
        step;
        while (rsp_v !== 1'b1 && n < 200) begin
            step;
            n++;
        end
        chk("rsp_data", e, rsp_d);
        rsp_r = 1'b1;
        step;
        rsp_r = 1'b0;
    endtask

    task automatic wait_ack(input logic v);
        int n = 0;
        while (ack_n !== v && n < 100) begin
            step;
            n++;
        end
        chk("bus_ack", {7'h00, v}, {7'h00, ack_n});
    endtask

    task automatic t_banks;
        for (int i = 0; i < 4; i++) do_op({i[1], 1'b1}, i[0], 1'b0, 4'h0, 8'(8'h10 + i));
        for (int i = 0; i < 4; i++) do_op({i[1], 1'b0}, i[0], 1'b0, 4'h0, 8'h00);
        repeat (30) step;
        chk("ready_full", 8'h00, {7'h00, req_r});
        for (int i = 0; i < 4; i++) get_rsp(8'(8'h10 + i));
        $display("test banks done");
    endtask

    task automatic t_ext;
        do_op(2'b01, 1'b0, 1'b1, 4'h9, 8'h77);
        do_op(2'b00, 1'b0, 1'b1, 4'h6, 8'h00);
        get_rsp(8'h77);
        chk("ext_latch", 8'h06, {4'h0, ext_q});
        $display("test ext done");
    endtask

    task automatic t_grant;
        do_op(2'b00, 1'b0, 1'b0, 4'h0, 8'h00);
        brq_n = 1'b0;
        wait_ack(1'b0);
        chk("grant_float", 8'h00, {6'h00, req_r, a_oe});
        // The expansion test last wrote this primary memory cell.
        get_rsp(8'h77);
        brq_n = 1'b1;
        wait_ack(1'b1);
        $display("test grant done");
    endtask

    task automatic t_wait;
        int n = 0;
        do_op(2'b00, 1'b0, 1'b0, 4'h0, 8'h00);
        wait_n = 1'b0;
        repeat (20) step;
        wait_n = 1'b1;
        while (rsp_v !== 1'b1 && n < 100) begin
            step;
            n++;
        end
        chk("wait_stretch", 8'h01, {7'h00, 1'(n > 4)});
        get_rsp(8'h77);
        pd_n = 1'b0;
        repeat (6) step;
        chk("pwr_fail", 8'h01, {7'h00, pfail});
        $display("test wait and power done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (2) step;
        rst = 1'b0;
        chk("idle_float", 8'h00, {5'h00, d_oe, a_oe, ctl_oe});
        t_banks;
        t_ext;
        t_grant;
        t_wait;
        print_verdict;
    end

    initial begin
        #100000;
        fails++;
        print_verdict;
    end
endmodule

bind bmp_master bmp_master_chk u_chk (.SYS_CLK, .SYS_RST, .BUS_D_OE, .BUS_A_O, .BUS_A_OE,
    .BUS_CTL_O, .BUS_CTL_OE, .BUS_ACK_N, .BUS_PWRDN_N, .PWR_FAIL);
